// File: rtl/bitplane_palette_video_out.sv
// bit-plane video memory, time-shared access and palette dot output
// How it works
// - one blue plane, plus green when fitted, or three planes for colour
// - controller and cpu share memory, one at a time
// - in colour mode, plane bits pick palette entry each dot; mono decodes them directly
// - mono green-only dot shows high brightness
// - mono green and blue dot shows normal, blinking
// - colour mode drives half and full lines per primary
// - never half and full of one primary together
// - off, half, full per primary give 27 colours
// - eight entries, each any of 27 colours, preset
`timescale 1ns/100ps
module bitplane_palette_video_out
  import video_out_pkg::*;
#(
  parameter int BLINK_CYC = video_out_pkg::BLINK_HALF_CYC
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // configuration straps
  input wire logic colour_mode,
  input wire logic green_fitted,
  // graphics display controller port
  input wire logic gdc_req,
  input wire logic gdc_we,
  input wire logic gdc_fetch,
  input wire logic [video_out_pkg::ADDR_W-1:0] gdc_addr,
  input wire video_out_pkg::plane_word_t gdc_wdata,
  input wire video_out_pkg::plane_sel_t gdc_wsel,
  output logic gdc_gnt,
  output video_out_pkg::plane_word_t gdc_rdata,
  output logic gdc_rvalid,
  // cpu port from the io bus
  input wire logic cpu_req,
  input wire logic cpu_we,
  input wire logic [video_out_pkg::ADDR_W-1:0] cpu_addr,
  input wire video_out_pkg::plane_sel_t cpu_sel,
  input wire logic [7:0] cpu_wdata,
  output logic cpu_gnt,
  output logic [7:0] cpu_rdata,
  output logic cpu_rvalid,
  // palette load port
  input wire logic pal_we,
  input wire logic [video_out_pkg::PAL_IDX_W-1:0] pal_addr,
  input wire video_out_pkg::pal_entry_t pal_wdata,
  // dot scan
  input wire logic dot_en,
  // monitor outputs
  output video_out_pkg::colour_lines_t colour_out,
  output video_out_pkg::mono_lines_t mono_out,
  output logic dot_underrun
);
  import video_out_pkg::*;

  // ==========================================================================
  // video memory planes
  logic [7:0] plane_blue [PLANE_BYTES];
  logic [7:0] plane_green [PLANE_BYTES];
  logic [7:0] plane_red [PLANE_BYTES];

  plane_sel_t fitted;
  assign fitted = '{red: colour_mode, green: colour_mode || green_fitted, blue: 1'b1};

  // ==========================================================================
  // time-shared access
  slot_t slot_q;
  logic fifo_in_ready;
  logic gdc_ok;
  logic gdc_take;
  logic cpu_take;

  // a fetch is held off while the dot FIFO is full
  assign gdc_ok = gdc_req && (!gdc_fetch || gdc_we || fifo_in_ready);

  always_comb begin
    unique case (slot_q)
      SLOT_GDC: begin
        gdc_take = gdc_ok;
        cpu_take = !gdc_ok && cpu_req;
      end
      SLOT_CPU: begin
        cpu_take = cpu_req;
        gdc_take = !cpu_req && gdc_ok;
      end
      default: begin
        gdc_take = 1'b0;
        cpu_take = 1'b0;
      end
    endcase
  end
  assign gdc_gnt = gdc_take;
  assign cpu_gnt = cpu_take;

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      slot_q <= SLOT_GDC;
    end else begin
      slot_q <= (slot_q == SLOT_GDC) ? SLOT_CPU : SLOT_GDC;
    end
  end

  logic [ADDR_W-1:0] mem_addr;
  assign mem_addr = cpu_take ? cpu_addr : gdc_addr;

  always_ff @(posedge clk_sys) begin
    if (gdc_take && gdc_we) begin
      if (gdc_wsel.blue) plane_blue[gdc_addr] <= gdc_wdata.blue;
      if (gdc_wsel.green && fitted.green) plane_green[gdc_addr] <= gdc_wdata.green;
      if (gdc_wsel.red && fitted.red) plane_red[gdc_addr] <= gdc_wdata.red;
    end else if (cpu_take && cpu_we) begin
      if (cpu_sel.blue) plane_blue[cpu_addr] <= cpu_wdata;
      if (cpu_sel.green && fitted.green) plane_green[cpu_addr] <= cpu_wdata;
      if (cpu_sel.red && fitted.red) plane_red[cpu_addr] <= cpu_wdata;
    end
  end

  // planes that are not fitted read as zero
  plane_word_t rd_word;
  assign rd_word.blue = plane_blue[mem_addr];
  assign rd_word.green = fitted.green ? plane_green[mem_addr] : 8'h00;
  assign rd_word.red = fitted.red ? plane_red[mem_addr] : 8'h00;

  logic [7:0] cpu_byte;
  always_comb begin
    cpu_byte = 8'h00;
    if (cpu_sel.blue) cpu_byte = cpu_byte | rd_word.blue;
    if (cpu_sel.green) cpu_byte = cpu_byte | rd_word.green;
    if (cpu_sel.red) cpu_byte = cpu_byte | rd_word.red;
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      gdc_rdata <= '0;
      gdc_rvalid <= 1'b0;
      cpu_rdata <= 8'h00;
      cpu_rvalid <= 1'b0;
    end else begin
      gdc_rvalid <= gdc_take && !gdc_we && !gdc_fetch;
      cpu_rvalid <= cpu_take && !cpu_we;
      if (gdc_take && !gdc_we) gdc_rdata <= rd_word;
      if (cpu_take && !cpu_we) cpu_rdata <= cpu_byte;
    end
  end

  // ==========================================================================
  // display fetch buffer
  logic fifo_out_valid;
  logic fifo_out_ready;
  plane_word_t fifo_out_data;

  plane_fifo #(
    .WIDTH($bits(plane_word_t)),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .in_valid(gdc_take && gdc_fetch && !gdc_we),
    .in_ready(fifo_in_ready),
    .in_data(rd_word),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out_data)
  );

  // ==========================================================================
  // dot shifter
  plane_word_t shift_q;
  logic [2:0] dot_cnt_q;
  logic loaded_q;
  logic need_word;

  assign need_word = dot_en && (!loaded_q || dot_cnt_q == DOT_LAST);
  assign fifo_out_ready = need_word;

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      shift_q <= '0;
      dot_cnt_q <= 3'h0;
      loaded_q <= 1'b0;
    end else if (need_word) begin
      // dot 0 is shown straight from the buffer, so the stored word starts at dot 1
      shift_q <= '{red: fifo_out_data.red << 1, green: fifo_out_data.green << 1,
                   blue: fifo_out_data.blue << 1};
      dot_cnt_q <= 3'h0;
      loaded_q <= fifo_out_valid;
    end else if (dot_en) begin
      shift_q <= '{red: shift_q.red << 1, green: shift_q.green << 1, blue: shift_q.blue << 1};
      dot_cnt_q <= dot_cnt_q + 3'h1;
    end
  end

  // an empty buffer in the scan shows index 0 (blank in mono, palette entry 0 in colour) rather than stale data
  logic dot_live;
  logic [PAL_IDX_W-1:0] dot_idx;
  assign dot_live = need_word ? fifo_out_valid : (dot_en && loaded_q);
  always_comb begin
    dot_idx = PAL_IDX_BLANK;
    if (dot_live && need_word) begin
      dot_idx = {fifo_out_data.red[7], fifo_out_data.green[7], fifo_out_data.blue[7]};
    end else if (dot_live) begin
      dot_idx = {shift_q.red[7], shift_q.green[7], shift_q.blue[7]};
    end
  end

  // ==========================================================================
  // palette
  pal_entry_t palette_q [PAL_ENTRIES];

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      for (int i = 0; i < PAL_ENTRIES; i++) begin
        palette_q[i] <= PAL_RESET;
      end
    end else if (pal_we) begin
      palette_q[pal_addr] <= pal_wdata;
    end
  end

  // ==========================================================================
  // blink phase
  logic [$clog2(BLINK_CYC+1)-1:0] blink_cnt_q;
  logic blink_phase_q;

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      blink_cnt_q <= '0;
      blink_phase_q <= 1'b0;
    end else if (blink_cnt_q == $bits(blink_cnt_q)'(BLINK_CYC - 1)) begin
      blink_cnt_q <= '0;
      blink_phase_q <= !blink_phase_q;
    end else begin
      blink_cnt_q <= blink_cnt_q + 1'b1;
    end
  end

  // ==========================================================================
  // output stage
  mono_lines_t mono_d;
  always_comb begin
    mono_d = '0;
    unique case ({dot_idx[1], dot_idx[0]})
      2'b00: mono_d = '0;
      2'b01: mono_d = '{video: 1'b1, bright: 1'b0, blink: 1'b0};
      2'b10: mono_d = '{video: 1'b1, bright: 1'b1, blink: 1'b0};
      2'b11: mono_d = '{video: !blink_phase_q, bright: 1'b0, blink: 1'b1};
    endcase
    if (!green_fitted && dot_idx[0]) begin
      mono_d = '{video: 1'b1, bright: 1'b0, blink: 1'b0};
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      colour_out <= '0;
      mono_out <= '0;
      dot_underrun <= 1'b0;
    end else begin
      colour_out <= colour_mode ? entry_lines(palette_q[dot_idx]) : '0;
      mono_out <= colour_mode ? '0 : mono_d;
      dot_underrun <= need_word && !fifo_out_valid;
    end
  end

  // ==========================================================================
  // checks
  sequence s_live_dot;
    dot_live && colour_mode;
  endsequence

  sequence s_green_only;
    dot_live && !colour_mode && green_fitted && dot_idx[1:0] == 2'b10;
  endsequence

  a_one_grant: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !(gdc_gnt && cpu_gnt)) else $error("both ports granted together");

  a_cpu_served: assert property (@(posedge clk_sys) disable iff (sys_rst)
    cpu_req |-> ##[0:1] cpu_gnt) else $error("cpu request starved");

  a_colour_pick: assert property (@(posedge clk_sys) disable iff (sys_rst)
    s_live_dot ##0 !pal_we |=> colour_out == entry_lines($past(palette_q[dot_idx])))
    else $error("colour differs from selected entry");

  a_half_full: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !(colour_out.red_half && colour_out.red_full) &&
    !(colour_out.green_half && colour_out.green_full) &&
    !(colour_out.blue_half && colour_out.blue_full)) else $error("half and full together");

  a_mono_bright: assert property (@(posedge clk_sys) disable iff (sys_rst)
    s_green_only |=> mono_out.video && mono_out.bright && !mono_out.blink)
    else $error("green-only dot not bright");

  a_mono_blink: assert property (@(posedge clk_sys) disable iff (sys_rst)
    dot_live && !colour_mode && green_fitted && dot_idx[1:0] == 2'b11
    |=> mono_out.blink && !mono_out.bright && mono_out.video == !$past(blink_phase_q))
    else $error("green and blue dot not blinking");

  a_mono_blank: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !colour_mode && !dot_idx[0] && !(green_fitted && dot_idx[1]) |=> mono_out == '0)
    else $error("index zero not blank");

  a_mono_no_red: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !colour_mode |-> rd_word.red == 8'h00) else $error("red plane seen in mono");

  a_pal_store: assert property (@(posedge clk_sys) disable iff (sys_rst)
    pal_we |=> palette_q[$past(pal_addr)] == $past(pal_wdata)) else $error("palette not stored");

  a_full_level: assert property (@(posedge clk_sys) disable iff (sys_rst)
    s_live_dot ##0 palette_q[dot_idx].red == LVL_FULL ##0 !pal_we
    |=> colour_out.red_full && !colour_out.red_half) else $error("full red level lost");

endmodule // bitplane_palette_video_out

// File: rtl/video_out_pkg.sv
// shared constants, carriers and helpers of the bit-plane palette video output stage
package video_out_pkg;

  // ==========================================================================
  // video memory geometry
  localparam int PLANE_BYTES = 32768;
  localparam int ADDR_W = 15;
  localparam int DOTS_PER_BYTE = 8;
  localparam logic [2:0] DOT_LAST = 3'h7;
  localparam int FIFO_DEPTH = 16;

  // ==========================================================================
  // palette
  localparam int PAL_ENTRIES = 8;
  localparam int PAL_IDX_W = 3;
  localparam logic [PAL_IDX_W-1:0] PAL_IDX_BLANK = 3'h0;
  localparam logic [1:0] LVL_OFF = 2'h0;
  localparam logic [1:0] LVL_HALF = 2'h1;
  localparam logic [1:0] LVL_FULL = 2'h2;

  // ==========================================================================
  // timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int BLINK_HALF_MS = 500;
  localparam int BLINK_HALF_CYC = BLINK_HALF_MS * 1000000 / CLK_PERIOD_NS;

  // ==========================================================================
  // carriers
  typedef struct packed {
    logic [7:0] red;
    logic [7:0] green;
    logic [7:0] blue;
  } plane_word_t;

  typedef struct packed {
    logic red;
    logic green;
    logic blue;
  } plane_sel_t;

  typedef struct packed {
    logic [1:0] red;
    logic [1:0] green;
    logic [1:0] blue;
  } pal_entry_t;

  typedef struct packed {
    logic red_half;
    logic red_full;
    logic green_half;
    logic green_full;
    logic blue_half;
    logic blue_full;
  } colour_lines_t;

  typedef struct packed {
    logic video;
    logic bright;
    logic blink;
  } mono_lines_t;

  localparam pal_entry_t PAL_RESET = 6'h00;

  // one-hot memory slot owner
  typedef enum logic [1:0] {
    SLOT_GDC = 2'b01,
    SLOT_CPU = 2'b10
  } slot_t;

  // ==========================================================================
  // helpers
  // a level of 3 (unused code) shows as off, so half and full never meet
  function automatic logic [1:0] level_lines(input logic [1:0] lvl);
    level_lines = {lvl == LVL_HALF, lvl == LVL_FULL};
  endfunction

  function automatic colour_lines_t entry_lines(input pal_entry_t e);
    logic [1:0] r;
    logic [1:0] g;
    logic [1:0] b;
    r = level_lines(e.red);
    g = level_lines(e.green);
    b = level_lines(e.blue);
    entry_lines = {r, g, b};
  endfunction

endpackage

// File: rtl/plane_fifo.sv
// synchronous valid/ready FIFO for fetched plane words
`timescale 1ns/100ps
module plane_fifo #(
  parameter int WIDTH = 24,
  parameter int DEPTH = 16
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_q;
  logic [AW:0] rd_q;
  logic push;
  logic pop;

  assign in_ready = (wr_q - rd_q) != (AW+1)'(DEPTH);
  assign out_valid = wr_q != rd_q;
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem[rd_q[AW-1:0]];

  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem[wr_q[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      wr_q <= wr_q + (AW+1)'(push);
      rd_q <= rd_q + (AW+1)'(pop);
    end
  end

endmodule // plane_fifo

// File: tb/crt_monitor_model.sv
// behavioural crt monitor watching the video lines of the device
`timescale 1ns/100ps
module crt_monitor_model
  import video_out_pkg::*;
(
  // clock
  input wire logic clk_sys,
  // video lines from the device
  input wire video_out_pkg::colour_lines_t colour_out,
  input wire video_out_pkg::mono_lines_t mono_out,
  // observations
  output int n_clash,
  output int n_lit
);
  // ====
  // guns
  initial n_clash = 0;
  initial n_lit = 0;
  // a gun driven half and full at once is out of spec for the tube
  always @(posedge clk_sys) begin
    if ((colour_out.red_half & colour_out.red_full) === 1'b1 ||
        (colour_out.green_half & colour_out.green_full) === 1'b1 ||
        (colour_out.blue_half & colour_out.blue_full) === 1'b1) begin
      n_clash <= n_clash + 1;
    end
    if (mono_out.video === 1'b1) begin
      n_lit <= n_lit + 1;
    end
  end
endmodule // crt_monitor_model

// File: tb/bitplane_palette_video_out_tb.sv
// self-checking testbench of the bit-plane palette video output stage
`timescale 1ns/100ps
`define CHK(a, b) chk(64'(a), 64'(b))
module bitplane_palette_video_out_tb
  import video_out_pkg::*;
;
  logic clk_sys, sys_rst, colour_mode, green_fitted, gdc_req, gdc_we, gdc_fetch;
  logic [ADDR_W-1:0] gdc_addr, cpu_addr, a;
  plane_word_t gdc_wdata, gdc_rdata, w;
  plane_sel_t gdc_wsel, cpu_sel;
  logic gdc_gnt, gdc_rvalid, cpu_req, cpu_we, cpu_gnt, cpu_rvalid, pal_we, dot_en, dot_underrun;
  logic [7:0] cpu_wdata, cpu_rdata, q;
  logic [PAL_IDX_W-1:0] pal_addr;
  pal_entry_t pal_wdata;
  colour_lines_t colour_out;
  mono_lines_t mono_out;
  pal_entry_t pal_m [PAL_ENTRIES];
  int n_mismatch, n_checks, n_clash, n_lit, seed, k, i, p;
  logic ok, u;
  localparam plane_word_t RAMP = {8'h0F, 8'h33, 8'h55};

  bitplane_palette_video_out #(.BLINK_CYC(8)) u_bitplane_palette_video_out (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .colour_mode(colour_mode),
    .green_fitted(green_fitted), .gdc_req(gdc_req), .gdc_we(gdc_we), .gdc_fetch(gdc_fetch),
    .gdc_addr(gdc_addr), .gdc_wdata(gdc_wdata), .gdc_wsel(gdc_wsel), .gdc_gnt(gdc_gnt),
    .gdc_rdata(gdc_rdata), .gdc_rvalid(gdc_rvalid), .cpu_req(cpu_req), .cpu_we(cpu_we),
    .cpu_addr(cpu_addr), .cpu_sel(cpu_sel), .cpu_wdata(cpu_wdata), .cpu_gnt(cpu_gnt),
    .cpu_rdata(cpu_rdata), .cpu_rvalid(cpu_rvalid), .pal_we(pal_we), .pal_addr(pal_addr),
    .pal_wdata(pal_wdata), .dot_en(dot_en), .colour_out(colour_out), .mono_out(mono_out),
    .dot_underrun(dot_underrun));

  crt_monitor_model u_crt_monitor_model (
    .clk_sys(clk_sys), .colour_out(colour_out), .mono_out(mono_out),
    .n_clash(n_clash), .n_lit(n_lit));

  // ====
  // helpers
  function automatic colour_lines_t col_exp(input pal_entry_t e);
    col_exp = {e.red == 2'h1, e.red == 2'h2, e.green == 2'h1, e.green == 2'h2,
               e.blue == 2'h1, e.blue == 2'h2};
  endfunction

  function automatic mono_lines_t mono_exp(input logic [1:0] ix);
    case (ix)
      2'h1: mono_exp = 3'h4;
      2'h2: mono_exp = 3'h6;
      default: mono_exp = 3'h0;
    endcase
  endfunction

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic tally_and_finish();
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic do_reset(input logic cm, input logic gf);
    @(negedge clk_sys);
    sys_rst = 1'b1;
    colour_mode = cm;
    green_fitted = gf;
    repeat (6) @(negedge clk_sys);
    sys_rst = 1'b0;
    `CHK({colour_out, mono_out, dot_underrun, gdc_rvalid, cpu_rvalid}, 0);
  endtask

  // requests are held until the grant is sampled at a rising edge
  task automatic gdc_acc(input logic we, input logic fe, input logic [ADDR_W-1:0] ad,
                         input plane_word_t d, output logic gr);
    int n;
    @(negedge clk_sys);
    gdc_req = 1'b1;
    gdc_we = we;
    gdc_fetch = fe;
    gdc_addr = ad;
    gdc_wdata = d;
    gdc_wsel = 3'h7;
    gr = 1'b0;
    for (n = 0; n < 20 && !gr; n++) begin
      #1;
      if (gdc_gnt === 1'b1) gr = 1'b1;
      @(posedge clk_sys);
    end
    @(negedge clk_sys);
    gdc_req = 1'b0;
  endtask

  task automatic cpu_acc(input logic we, input plane_sel_t s, input logic [ADDR_W-1:0] ad,
                         input logic [7:0] d, output logic [7:0] r);
    int n;
    logic gr;
    @(negedge clk_sys);
    cpu_req = 1'b1;
    cpu_we = we;
    cpu_sel = s;
    cpu_addr = ad;
    cpu_wdata = d;
    gr = 1'b0;
    for (n = 0; n < 20 && !gr; n++) begin
      #1;
      if (cpu_gnt === 1'b1) gr = 1'b1;
      @(posedge clk_sys);
    end
    @(negedge clk_sys);
    cpu_req = 1'b0;
    r = cpu_rdata;
    `CHK({gr, cpu_rvalid}, {1'b1, !we});
  endtask

  // dot i is consumed at the (i+1)th edge with dot_en high and shows right after it
  task automatic run_dots(input plane_word_t d);
    int j;
    logic [2:0] ix;
    logic [1:0] mi;
    @(negedge clk_sys);
    dot_en = 1'b1;
    for (j = 0; j < 9; j++) begin
      @(negedge clk_sys);
      if (j == 7) dot_en = 1'b0;
      if (j < 8) begin
        ix = {d.red[7-j], d.green[7-j], d.blue[7-j]};
        mi = green_fitted ? ix[1:0] : {1'b0, ix[0]};
        if (colour_mode) begin
          `CHK({colour_out, mono_out}, {col_exp(pal_m[ix]), 3'h0});
        end else if (mi == 2'h3) begin
          `CHK({colour_out, mono_out.bright, mono_out.blink}, 8'h01);
        end else begin
          `CHK({colour_out, mono_out}, {6'h00, mono_exp(mi)});
        end
      end
    end
  endtask

  // ====
  // clock and watchdog
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  initial begin
    #200000;
    n_mismatch++;
    tally_and_finish();
  end

  // ====
  // scenarios
  initial begin
    seed = 31394;
    {sys_rst, colour_mode, green_fitted, gdc_req, gdc_we, gdc_fetch} = 6'h20;
    {gdc_addr, cpu_addr, gdc_wdata, gdc_wsel, cpu_sel} = 0;
    {cpu_req, cpu_we, cpu_wdata, pal_we, pal_addr, pal_wdata, dot_en} = 0;
    n_mismatch = 0;
    n_checks = 0;
    do_reset(1'b1, 1'b0);
    // early rounds sweep all 27 colours, later rounds use random entries
    for (k = 0; k < 8; k++) begin
      for (i = 0; i < PAL_ENTRIES; i++) begin
        p = (8 * k + i) % 27;
        pal_m[i] = (k < 4) ? {2'(p / 9), 2'(p / 3 % 3), 2'(p % 3)} : 6'($random(seed));
      end
      @(negedge clk_sys);
      pal_we = 1'b1;
      for (i = 0; i < PAL_ENTRIES; i++) begin
        pal_addr = 3'(i);
        pal_wdata = pal_m[i];
        @(negedge clk_sys);
      end
      pal_we = 1'b0;
      w = (k < 4) ? RAMP : 24'($random(seed));
      a = 15'($random(seed));
      gdc_acc(1'b1, 1'b0, a, w, ok);
      `CHK(ok, 1'b1);
      gdc_acc(1'b0, 1'b0, a, w, ok);
      `CHK({ok, gdc_rvalid, gdc_rdata}, {1'b1, 1'b1, w});
      fork
        for (p = 0; p < 3; p++) begin
          cpu_acc(1'b0, 3'(1 << p), a, 8'h00, q);
          `CHK(q, 8'(w >> (8 * p)));
        end
        gdc_acc(1'b0, 1'b1, a, w, ok);
      join
      `CHK(ok, 1'b1);
      run_dots(w);
    end
    @(negedge clk_sys);
    dot_en = 1'b1;
    @(negedge clk_sys);
    dot_en = 1'b0;
    u = dot_underrun;
    @(negedge clk_sys);
    `CHK(u | dot_underrun, 1'b1);
    for (i = 0; i < FIFO_DEPTH + 1; i++) begin
      gdc_acc(1'b0, 1'b1, a, w, ok);
      `CHK(ok, i < FIFO_DEPTH);
    end
    for (i = 0; i < FIFO_DEPTH; i++) run_dots(w);
    do_reset(1'b0, 1'b1);
    gdc_acc(1'b1, 1'b0, 15'h0005, RAMP, ok);
    gdc_acc(1'b0, 1'b1, 15'h0005, RAMP, ok);
    run_dots(RAMP);
    gdc_acc(1'b1, 1'b0, 15'h0006, 24'hFF_FFFF, ok);
    repeat (2) gdc_acc(1'b0, 1'b1, 15'h0006, 24'hFF_FFFF, ok);
    p = n_lit;
    @(negedge clk_sys);
    dot_en = 1'b1;
    repeat (16) @(negedge clk_sys);
    dot_en = 1'b0;
    `CHK((n_lit - p) > 0 && (n_lit - p) < 16, 1'b1);
    do_reset(1'b0, 1'b0);
    cpu_acc(1'b1, 3'h2, 15'h0009, 8'hFF, q);
    cpu_acc(1'b0, 3'h2, 15'h0009, 8'h00, q);
    `CHK(q, 8'h00);
    gdc_acc(1'b1, 1'b0, 15'h0009, RAMP, ok);
    gdc_acc(1'b0, 1'b1, 15'h0009, RAMP, ok);
    run_dots(RAMP);
    `CHK(n_clash, 0);
    tally_and_finish();
  end
endmodule // bitplane_palette_video_out_tb
